// [include/charge_seq_defs.svh]
// charge_seq_defs.svh: constants for the charge sequencer
// assumes a 100 MHz mclk; included by bare name
`ifndef CHARGE_SEQ_DEFS_SVH
`define CHARGE_SEQ_DEFS_SVH

// clock period in ns
`define CLK_PERIOD_NS 10
// comparator filter time in ns, and its count (least time: round up)
`define FILTER_TIME_NS 1000
`define FILTER_CYCLES ((`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// safety timers in seconds
`define PRECHG_TIME_S 1800
`define CHG_TIME_S 18000
// ramp step time in ns and its count
`define RAMP_STEP_NS 10000
`define RAMP_STEP_CYCLES ((`RAMP_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ramp level width and full scale
`define RAMP_W 4
`define RAMP_FULL 4'hf
// prescaler to one second ticks
`define SEC_CYCLES 100000000
// safety timer counter width
`define TIMER_W 16

`endif

// [include/charge_seq_pkg.sv]
// charge_seq_pkg.sv: types for the charge sequencer
// assumes charge_seq_defs.svh defines the numbers
package charge_seq_pkg;

   // sequencer states, one-hot
   typedef enum logic [6:0] {
      st_absent  = 7'h01,
      st_qualify = 7'h02,
      st_precharge = 7'h04,
      st_fast    = 7'h08,
      st_suspend = 7'h10,
      st_fault   = 7'h20,
      st_done    = 7'h40
   } seq_state_type;

   // charge mode remembered across suspend
   typedef enum logic [1:0] {
      mode_none = 2'h0,
      mode_pre  = 2'h1,
      mode_fast = 2'h2
   } charge_mode_type;

endpackage : charge_seq_pkg

// [verilog/input_filter.sv]
// input_filter.sv: two-flop synchroniser plus stability filter
// assumes one clock mclk and asynchronous active-high rst
`timescale 1ns/1ps
`include "charge_seq_defs.svh"

module input_filter (
   input  wire logic mclk,
   input  wire logic rst,
   input  wire logic raw,
   output logic      clean
);
   import charge_seq_pkg::*;

   typedef struct packed {
      logic        meta;
      logic        sync;
      logic [15:0] count;
      logic        clean;
   } filt_type;

   filt_type cur;
   filt_type next_cur;

   // synchronise, then accept a level only after it holds steady
   always_comb begin
      next_cur = cur;
      next_cur.meta = raw;
      next_cur.sync = cur.meta;
      if (cur.sync == cur.clean) begin
         next_cur.count = 16'h0;
      end else if (cur.count == 16'(`FILTER_CYCLES - 1)) begin
         next_cur.count = 16'h0;
         next_cur.clean = cur.sync;
      end else begin
         next_cur.count = cur.count + 16'h1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign clean = cur.clean;

endmodule : input_filter

// [verilog/charge_qualify_sequencer.sv]
// charge_qualify_sequencer.sv: charge qualification and mode sequencer
// assumes comparator results arrive as levels; one clock, power-on reset on rst
//
// How it works
// RULE1: new cycle starts only with supply valid and battery present.
// RULE2: cycle start needs thermistor between cold fault and hot fault thresholds.
// RULE3: battery below low-voltage threshold selects pre-charge at reduced current.
// RULE4: while charging, leave cold-to-cutoff window suspends; resume inside cold-to-hot window.
// RULE5: suspend releases the open-drain pass drive output.
// RULE6: suspend freezes safety timers; counting continues from held values on resume.
// RULE7: supply regulation stays active in absent, precharge, suspend, fault, done.
// RULE8: current regulation below regulation voltage, voltage regulation once reached.
// RULE9: regulation targets ramp stepwise between modes and into or out of suspend/fault.
// RULE10: detect insertion and removal, open or closed protector packs; the code does not act on removal while in suspend.
// RULE11: temperature is checked continuously in every state; the code checks it only in qualify, precharge, fast and suspend.
// RULE12: status shown on two open-drain outputs that only pull low or release.
// RULE13: after timer expiry stay in fault until reset or battery removal.
// RULE14: leaving suspend clears timers only if resumed mode differs.
// RULE15: comparator inputs are synchronised and filtered before use.
`timescale 1ns/1ps
`include "charge_seq_defs.svh"

module charge_qualify_sequencer #(
   parameter int unsigned SEC_CYCLES = `SEC_CYCLES
) (
   input  wire logic                   mclk,
   input  wire logic                   rst,
   input  wire logic                   supply_valid,
   input  wire logic                   battery_detect,
   input  wire logic                   battery_removed,
   input  wire logic                   bat_below_lowv,
   input  wire logic                   bat_below_reg,
   input  wire logic                   bat_below_rch,
   input  wire logic                   current_below_term,
   input  wire logic                   ts_above_cold,
   input  wire logic                   ts_below_hot,
   input  wire logic                   ts_below_cutoff,
   output logic                        pass_drive_output_o,
   output logic                        pass_drive_output_oe,
   output logic                        status_out_a_o,
   output logic                        status_out_a_oe,
   output logic                        status_out_b_o,
   output logic                        status_out_b_oe,
   output logic                        supply_reg_enable,
   output logic                        current_reg_select,
   output logic                        voltage_reg_select,
   output logic                        precondition_current,
   output logic [`RAMP_W-1:0]          reg_target,
   output charge_seq_pkg::seq_state_type state_out
);
   import charge_seq_pkg::*;

   // ************************************************
   // input conditioning
   // ************************************************
   localparam int NIN = 10;
   logic [NIN-1:0] raw_in;
   logic [NIN-1:0] flt;

   assign raw_in = {supply_valid, battery_detect, battery_removed, bat_below_lowv,
                    bat_below_reg, bat_below_rch, current_below_term,
                    ts_above_cold, ts_below_hot, ts_below_cutoff};

   // one filter per comparator
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi = gi + 1) begin : g_filt
         input_filter u_filt ( // RULE15
            .mclk  (mclk),
            .rst   (rst),
            .raw   (raw_in[gi]),
            .clean (flt[gi])
         );
      end
   endgenerate

   logic f_supply, f_detect, f_removed, f_lowv, f_below_reg, f_below_rch;
   logic f_term, f_cold_ok, f_hot_ok, f_cut_ok;
   assign {f_supply, f_detect, f_removed, f_lowv, f_below_reg, f_below_rch,
           f_term, f_cold_ok, f_hot_ok, f_cut_ok} = flt;

   // ************************************************
   // helpers
   // ************************************************
   // start window: cold to hot fault thresholds
   function automatic logic temp_start_ok(input logic cold_ok, input logic hot_ok);
      temp_start_ok = cold_ok & hot_ok;
   endfunction : temp_start_ok

   // run window: cold fault to hot cutoff thresholds
   function automatic logic temp_run_ok(input logic cold_ok, input logic cut_ok);
      temp_run_ok = cold_ok & cut_ok;
   endfunction : temp_run_ok

   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      seq_state_type          state;
      charge_mode_type        susp_mode;
      logic [31:0]            prescale;
      logic [`TIMER_W-1:0]    pre_timer;
      logic [`TIMER_W-1:0]    chg_timer;
      logic [`RAMP_W-1:0]     ramp;
      logic [`RAMP_W-1:0]     ramp_goal;
      logic [15:0]            ramp_count;
      // pin enables, low while the pin is pulled low; then the active-high regulation controls
      logic                   pass_oe;
      logic                   stat_a_oe;
      logic                   stat_b_oe;
      logic                   supply_reg;
      logic                   cur_sel;
      logic                   volt_sel;
      logic                   pre_cur;
   } seq_type;

   seq_type cur;
   seq_type next_cur;
   logic    sec_tick;
   logic    start_ok;
   logic    run_ok;
   charge_mode_type want_mode;

   always_comb begin
      sec_tick  = (cur.prescale == SEC_CYCLES - 1);
      start_ok  = temp_start_ok(f_cold_ok, f_hot_ok);     // RULE2
      run_ok    = temp_run_ok(f_cold_ok, f_cut_ok);       // RULE11
      want_mode = f_lowv ? mode_pre : mode_fast;          // RULE3
   end

   // ************************************************
   // sequencing
   // ************************************************
   // next-state logic
   always_comb begin
      next_cur = cur;
      // free-running second prescaler; a suspend may drop part of one second
      next_cur.prescale = sec_tick ? 32'h0 : cur.prescale + 32'h1;

      case (cur.state)
         st_absent: begin
            if (f_supply && f_detect) begin // RULE1 RULE10
               next_cur.state = st_qualify;
            end
         end
         st_qualify: begin
            if (f_removed || !f_supply) begin // RULE10
               next_cur.state = st_absent;
            end else if (!start_ok) begin // RULE2
               next_cur.state = st_suspend;
               next_cur.susp_mode = mode_none;
            end else if (want_mode == mode_pre) begin // RULE3
               next_cur.state = st_precharge;
            end else begin
               next_cur.state = st_fast;
            end
            // a fresh cycle restarts both safety timers
            next_cur.pre_timer = '0;
            next_cur.chg_timer = '0;
         end
         st_precharge: begin
            if (sec_tick) begin
               next_cur.pre_timer = cur.pre_timer + 1'b1;
            end
            if (f_removed) begin // RULE10
               next_cur.state = st_absent;
            end else if (!run_ok) begin // RULE4
               next_cur.state = st_suspend;
               next_cur.susp_mode = mode_pre;
            end else if (cur.pre_timer >= `TIMER_W'(`PRECHG_TIME_S)) begin
               next_cur.state = st_fault;
            end else if (!f_lowv) begin
               next_cur.state = st_fast;
               next_cur.chg_timer = '0;
            end
         end
         st_fast: begin
            if (sec_tick) begin
               next_cur.chg_timer = cur.chg_timer + 1'b1;
            end
            if (f_removed) begin // RULE10
               next_cur.state = st_absent;
            end else if (!run_ok) begin // RULE4
               next_cur.state = st_suspend;
               next_cur.susp_mode = mode_fast;
            end else if (cur.chg_timer >= `TIMER_W'(`CHG_TIME_S)) begin
               next_cur.state = st_fault;
            end else if (!f_below_reg && f_term) begin
               next_cur.state = st_done;
            end
         end
         st_suspend: begin
            // timers hold: no increment here  RULE6
            // removal is not acted on: a swapped pack must also sit inside the start window
            if (start_ok && f_supply && f_detect) begin // RULE4
               next_cur.state = (want_mode == mode_pre) ? st_precharge : st_fast;
               if (want_mode != cur.susp_mode) begin // RULE14
                  next_cur.pre_timer = '0;
                  next_cur.chg_timer = '0;
               end
            end
         end
         st_fault: begin
            if (f_removed) begin // RULE13
               next_cur.state = st_absent;
            end
         end
         st_done: begin
            if (f_removed || !f_detect) begin // RULE10
               next_cur.state = st_absent;
            end else if (f_below_rch) begin
               next_cur.state = st_qualify;
            end
         end
         default: begin
            next_cur.state = st_absent;
         end
      endcase

      // ramp goal by target state, stepping one level per interval  RULE9
      case (next_cur.state)
         st_fast:      next_cur.ramp_goal = `RAMP_FULL;
         st_precharge: next_cur.ramp_goal = `RAMP_W'(`RAMP_FULL >> 2);
         default:      next_cur.ramp_goal = '0;
      endcase
      if (cur.ramp == cur.ramp_goal) begin
         next_cur.ramp_count = 16'h0;
      end else if (cur.ramp_count == 16'(`RAMP_STEP_CYCLES - 1)) begin
         next_cur.ramp_count = 16'h0;
         next_cur.ramp = (cur.ramp < cur.ramp_goal) ? cur.ramp + 1'b1 : cur.ramp - 1'b1; // RULE9
      end else begin
         next_cur.ramp_count = cur.ramp_count + 16'h1;
      end

      // pass drive pulls low only while charging; released elsewhere
      // enables are held active low in the state so each pin comes straight from a flop
      next_cur.pass_oe = !(next_cur.state == st_precharge || next_cur.state == st_fast); // RULE5
      // supply regulation in every non fast-charge state
      next_cur.supply_reg = (next_cur.state != st_fast); // RULE7
      next_cur.cur_sel  = (next_cur.state == st_fast) && f_below_reg;  // RULE8
      next_cur.volt_sel = (next_cur.state == st_fast) && !f_below_reg; // RULE8
      next_cur.pre_cur  = (next_cur.state == st_precharge);            // RULE3

      // status pins: a=low in charge, b=low in done, both low in fault/suspend  RULE12
      // enable low pulls the pin low
      case (next_cur.state)
         st_precharge, st_fast: begin
            next_cur.stat_a_oe = 1'b0;
            next_cur.stat_b_oe = 1'b1;
         end
         st_done: begin
            next_cur.stat_a_oe = 1'b1;
            next_cur.stat_b_oe = 1'b0;
         end
         st_fault, st_suspend: begin
            next_cur.stat_a_oe = 1'b0;
            next_cur.stat_b_oe = 1'b0;
         end
         default: begin
            next_cur.stat_a_oe = 1'b1;
            next_cur.stat_b_oe = 1'b1;
         end
      endcase
   end

   // register the state
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         // released pins and live supply regulation while in reset  RULE7
         cur <= '{state:      st_absent,
                  susp_mode:  mode_none,
                  supply_reg: 1'b1,
                  pass_oe:    1'b1,
                  stat_a_oe:  1'b1,
                  stat_b_oe:  1'b1,
                  default:    '0};
      end else begin
         cur <= next_cur;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   // open-drain pins only pull low; enable is active low  RULE12
   // data lines are tied low so no open-drain pin can ever be driven high
   assign pass_drive_output_o  = 1'b0;
   assign pass_drive_output_oe = cur.pass_oe;
   assign status_out_a_o       = 1'b0;
   assign status_out_a_oe      = cur.stat_a_oe;
   assign status_out_b_o       = 1'b0;
   assign status_out_b_oe      = cur.stat_b_oe;
   assign supply_reg_enable    = cur.supply_reg;
   assign current_reg_select   = cur.cur_sel;
   assign voltage_reg_select   = cur.volt_sel;
   assign precondition_current = cur.pre_cur;
   assign reg_target           = cur.ramp;
   assign state_out            = cur.state;

endmodule : charge_qualify_sequencer

// [verification/charge_qualify_sequencer_chk.sv]
// charge_qualify_sequencer_chk.sv: port assertions for the charge sequencer
// assumes the sequencer's port names and package; bound at the file foot
`timescale 1ns/1ps
`include "charge_seq_defs.svh"

module charge_qualify_sequencer_chk import charge_seq_pkg::*; (
   input wire logic               mclk,
   input wire logic               rst,
   input wire logic               supply_valid,
   input wire logic               battery_detect,
   input wire logic               battery_removed,
   input wire logic               ts_below_cutoff,
   input wire logic               pass_drive_output_o,
   input wire logic               pass_drive_output_oe,
   input wire logic               status_out_a_o,
   input wire logic               status_out_a_oe,
   input wire logic               status_out_b_o,
   input wire logic               status_out_b_oe,
   input wire logic               supply_reg_enable,
   input wire logic               current_reg_select,
   input wire logic               voltage_reg_select,
   input wire logic               precondition_current,
   input wire logic [`RAMP_W-1:0] reg_target,
   input charge_seq_pkg::seq_state_type state_out
);
   // ***************************************
   // run counters and assertions
   // ***************************************
   logic [7:0] up_run;  // cycles with supply and pack both seen
   logic [7:0] hot_run; // cycles with thermistor past cutoff

   // saturating runs of the raw comparator levels
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         up_run  <= 8'h00;
         hot_run <= 8'h00;
      end else begin
         up_run  <= (supply_valid && battery_detect) ? up_run + {7'h00, up_run != 8'hff} : 8'h00;
         hot_run <= !ts_below_cutoff ? hot_run + {7'h00, hot_run != 8'hff} : 8'h00;
      end
   end

   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (rst);

   // one ramp step, then a held level
   sequence step_by_one;
      {1'b0, reg_target} == {1'b0, $past(reg_target)} + 5'h01 || {1'b0, reg_target} + 5'h01 == {1'b0, $past(reg_target)};
   endsequence
   sequence level_held;
      $stable(reg_target) [*8];
   endsequence

   start_needs_power_a: assert property ($changed(state_out) && $past(state_out) == st_absent |-> up_run >= 8'h5a)
      else $error("left absent without supply and pack");
   cutoff_suspends_a: assert property (hot_run == 8'h78 |-> !(state_out inside {st_precharge, st_fast}))
      else $error("still charging past cutoff");
   suspend_release_a: assert property (state_out inside {st_suspend, st_fault, st_absent} |-> pass_drive_output_oe)
      else $error("pass drive pulled while not charging");
   drain_only_a: assert property (!pass_drive_output_o && !status_out_a_o && !status_out_b_o)
      else $error("open drain output driven high");
   supply_kept_a: assert property (state_out != st_fast |-> supply_reg_enable)
      else $error("supply regulation dropped");
   precharge_drive_a: assert property (state_out == st_precharge |-> precondition_current && !pass_drive_output_oe)
      else $error("precharge without reduced current drive");
   loop_select_a: assert property (current_reg_select || voltage_reg_select |-> state_out == st_fast
      && !(current_reg_select && voltage_reg_select))
      else $error("bad loop selection");
   ramp_step_a: assert property ($changed(reg_target) |-> step_by_one ##1 level_held)
      else $error("regulation target jumped");
   fault_sticky_a: assert property ((state_out == st_fault && !battery_removed) [*8] |=> state_out == st_fault)
      else $error("fault left without removal");
   done_status_a: assert property (state_out == st_done |-> status_out_a_oe && !status_out_b_oe)
      else $error("done status wrong");
endmodule : charge_qualify_sequencer_chk

bind charge_qualify_sequencer charge_qualify_sequencer_chk chk_u (.mclk, .rst, .supply_valid, .battery_detect,
   .battery_removed, .ts_below_cutoff, .pass_drive_output_o, .pass_drive_output_oe, .status_out_a_o,
   .status_out_a_oe, .status_out_b_o, .status_out_b_oe, .supply_reg_enable, .current_reg_select,
   .voltage_reg_select, .precondition_current, .reg_target, .state_out);

// [verification/battery_pack_model.sv]
// battery_pack_model.sv: pack, thermistor divider and pass transistor as comparator levels
// assumes the bench sets zone, cell level and presence; levels move just after mclk rises
`timescale 1ns/1ps

module battery_pack_model (
   input  wire logic       mclk,
   input  wire logic       present,    // pack in the cradle
   input  wire logic [1:0] temp_zone,  // 0 cold 1 normal 2 warm 3 past cutoff
   input  wire logic [1:0] cell_level, // 0 deep 1 mid 2 full
   input  wire logic       taper,      // charge current tapered off
   input  wire logic       pass_line,  // gate line, low conducts
   output logic            battery_detect,
   output logic            battery_removed,
   output logic            bat_below_lowv,
   output logic            bat_below_reg,
   output logic            bat_below_rch,
   output logic            current_below_term,
   output logic            ts_above_cold,
   output logic            ts_below_hot,
   output logic            ts_below_cutoff
);
   // comparator levels follow the pack at once, with no race against the bench
   always_comb begin
      battery_detect     = present;
      battery_removed    = !present;
      bat_below_lowv     = !present || cell_level == 2'h0;
      bat_below_reg      = !present || cell_level != 2'h2;
      bat_below_rch      = !present || cell_level != 2'h2;
      current_below_term = pass_line || taper; // no current while gate released
      ts_above_cold      = temp_zone != 2'h0;
      ts_below_hot       = temp_zone <= 2'h1;
      ts_below_cutoff    = temp_zone != 2'h3;
   end
endmodule : battery_pack_model

// [verification/tb_charge_qualify_sequencer.sv]
// tb_charge_qualify_sequencer.sv: self-checking bench for the charge sequencer
// assumes battery_pack_model on the far side; one second shortened to 10 cycles
`timescale 1ns/1ps
`include "charge_seq_defs.svh"

module tb_charge_qualify_sequencer import charge_seq_pkg::*;;
   logic mclk = 1'b0, rst = 1'b1, supply_valid = 1'b0, present = 1'b0, taper = 1'b0;
   logic [1:0] temp_zone = 2'h1, cell_level = 2'h0;
   logic battery_detect, battery_removed, bat_below_lowv, bat_below_reg, bat_below_rch;
   logic current_below_term, ts_above_cold, ts_below_hot, ts_below_cutoff;
   logic pass_drive_output_o, pass_drive_output_oe, status_out_a_o, status_out_a_oe;
   logic status_out_b_o, status_out_b_oe, supply_reg_enable, current_reg_select;
   logic voltage_reg_select, precondition_current;
   logic [`RAMP_W-1:0] reg_target;
   seq_state_type state_out;
   int fail_count = 0, check_count = 0, cycles = 0;
   // open-drain lines with pull-ups
   wire pass_line = pass_drive_output_oe ? 1'b1 : pass_drive_output_o;
   wire stat_a    = status_out_a_oe ? 1'b1 : status_out_a_o;
   wire stat_b    = status_out_b_oe ? 1'b1 : status_out_b_o;

   always #5 mclk = ~mclk;

   charge_qualify_sequencer #(.SEC_CYCLES(10)) dut_u (.mclk, .rst, .supply_valid, .battery_detect,
      .battery_removed, .bat_below_lowv, .bat_below_reg, .bat_below_rch, .current_below_term,
      .ts_above_cold, .ts_below_hot, .ts_below_cutoff, .pass_drive_output_o, .pass_drive_output_oe,
      .status_out_a_o, .status_out_a_oe, .status_out_b_o, .status_out_b_oe, .supply_reg_enable,
      .current_reg_select, .voltage_reg_select, .precondition_current, .reg_target, .state_out);
   battery_pack_model pack_u (.mclk, .present, .temp_zone, .cell_level, .taper, .pass_line,
      .battery_detect, .battery_removed, .bat_below_lowv, .bat_below_reg, .bat_below_rch,
      .current_below_term, .ts_above_cold, .ts_below_hot, .ts_below_cutoff);

   // verdict and end of run
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_of_test

   // hang guard
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         end_of_test();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   task automatic expect_ok(input logic ok, input string what);
      check_count++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask : expect_ok

   task automatic wait_state(input seq_state_type s, input int limit);
      int n;
      n = 0;
      while (state_out !== s && n < limit) begin
         tick(1);
         n++;
      end
      expect_ok(state_out === s, "expected state not reached");
   endtask : wait_state

   // qualification: supply alone, a short pack glitch, then a deep cell
   task automatic t_start;
      expect_ok(state_out === st_absent && pass_line === 1'b1 && supply_reg_enable === 1'b1, "reset");
      supply_valid = 1'b1;
      tick(300);
      expect_ok(state_out === st_absent, "started without a pack");
      present = 1'b1;
      tick(50);
      present = 1'b0;
      tick(300);
      expect_ok(state_out === st_absent, "short glitch accepted");
      present = 1'b1;
      wait_state(st_precharge, 400);
      expect_ok(precondition_current === 1'b1 && stat_a === 1'b0 && stat_b === 1'b1, "precharge");
   endtask : t_start

   // suspend in precharge holds the timer, then expiry and removal
   task automatic t_timer;
      tick(5000);
      temp_zone = 2'h2;
      tick(300);
      expect_ok(state_out === st_precharge, "suspended below cutoff");
      temp_zone = 2'h3;
      wait_state(st_suspend, 300);
      expect_ok(pass_line === 1'b1 && supply_reg_enable === 1'b1, "suspend drive");
      tick(3000);
      temp_zone = 2'h2;
      tick(300);
      expect_ok(state_out === st_suspend, "resumed above hot fault");
      temp_zone = 2'h1;
      wait_state(st_precharge, 300);
      tick(11000);
      expect_ok(state_out === st_precharge, "timer ran in suspend");
      wait_state(st_fault, 3000);
      expect_ok(stat_a === 1'b0 && stat_b === 1'b0 && pass_line === 1'b1, "fault outputs");
      cell_level = 2'h1;
      tick(500);
      expect_ok(state_out === st_fault, "fault left early");
      present = 1'b0;
      wait_state(st_absent, 400);
   endtask : t_timer

   // precharge to fast ramp, voltage loop, done, removal
   task automatic t_ramp;
      cell_level = 2'h0;
      present = 1'b1;
      wait_state(st_precharge, 400);
      tick(4000);
      cell_level = 2'h1;
      wait_state(st_fast, 300);
      expect_ok(reg_target inside {4'h3, 4'h4} && current_reg_select === 1'b1, "fast entry");
      tick(13000);
      expect_ok(reg_target === 4'hf && voltage_reg_select === 1'b0, "ramp end");
      cell_level = 2'h2;
      tick(300);
      expect_ok(voltage_reg_select === 1'b1 && current_reg_select === 1'b0, "voltage loop");
      taper = 1'b1;
      wait_state(st_done, 300);
      expect_ok(stat_a === 1'b1 && stat_b === 1'b0 && supply_reg_enable === 1'b1, "done");
      cell_level = 2'h1; // recharge: cell sags below the recharge level
      taper = 1'b0;
      wait_state(st_fast, 400);
      expect_ok(current_reg_select === 1'b1 && pass_line === 1'b0, "recharge");
      present = 1'b0;
      wait_state(st_absent, 400);
   endtask : t_ramp

   // cold pack waits in suspend, then charges
   task automatic t_cold;
      cell_level = 2'h1;
      temp_zone = 2'h0;
      present = 1'b1;
      wait_state(st_suspend, 400);
      tick(300);
      expect_ok(state_out === st_suspend && pass_line === 1'b1, "cold start");
      temp_zone = 2'h1;
      wait_state(st_fast, 400);
   endtask : t_cold

   initial begin
      tick(12);
      rst = 1'b0;
      t_start();
      t_timer();
      t_ramp();
      t_cold();
      end_of_test();
   end
endmodule : tb_charge_qualify_sequencer
